// File: rtl/tpwmc_pkg.sv
// Constants shared by the timer/PWM counter core
`default_nettype none
package tpwmc_pkg;
    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] TPWMC_IDX_STATUS_CONTROL = 8'h10;
    localparam logic [7:0] TPWMC_IDX_COUNTER_HIGH   = 8'h11;
    localparam logic [7:0] TPWMC_IDX_COUNTER_LOW    = 8'h12;
    localparam logic [7:0] TPWMC_IDX_MODULO_HIGH    = 8'h13;
    localparam logic [7:0] TPWMC_IDX_MODULO_LOW     = 8'h14;
    localparam logic [7:0] TPWMC_IDX_SYSTEM_OPTION  = 8'h18;
    localparam logic [7:0] TPWMC_IDX_CHAN0_MODE     = 8'h19;
    localparam logic [7:0] TPWMC_IDX_CHAN1_MODE     = 8'h1A;
    localparam int         TPWMC_ADDR_W             = 12;
    // Status/control field positions
    localparam int TPWMC_BIT_OVF_FLAG   = 7;
    localparam int TPWMC_BIT_OVF_IRQ_EN = 6;
    localparam int TPWMC_BIT_CENTER     = 5;
    localparam int TPWMC_CLK_SRC_HI     = 4;
    localparam int TPWMC_CLK_SRC_LO     = 3;
    localparam int TPWMC_PRESCALE_HI    = 2;
    localparam int TPWMC_BIT_ROUTE_SEL  = 0;
    // Clock source codes
    localparam logic [1:0] TPWMC_CLK_NONE   = 2'h0;
    localparam logic [1:0] TPWMC_CLK_BUS    = 2'h1;
    localparam logic [1:0] TPWMC_CLK_UNUSED = 2'h2;
    localparam logic [1:0] TPWMC_CLK_XTAL   = 2'h3;
    // Channel mode codes
    localparam logic [1:0] TPWMC_MODE_GPIO    = 2'h0;
    localparam logic [1:0] TPWMC_MODE_CAPTURE = 2'h1;
    // Reset values and counter limits
    localparam logic [7:0]  TPWMC_SC_RESET  = 8'h00;
    localparam logic [15:0] TPWMC_CNT_RESET = 16'h0000;
    localparam logic [15:0] TPWMC_MOD_RESET = 16'h0000;
    localparam logic [15:0] TPWMC_CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] TPWMC_CNT_ZERO  = 16'h0000;
    localparam int          TPWMC_PRE_W     = 7;
    localparam int          TPWMC_CHANNELS  = 2;
    // Crystal-derived clock rate and bus clock rate (kHz)
    localparam int TPWMC_XTAL_KHZ = 500;
    localparam int TPWMC_MCLK_KHZ = 200000;
    localparam int TPWMC_XTAL_PERIOD_CYCLES = TPWMC_MCLK_KHZ / TPWMC_XTAL_KHZ;
    // Register selector
    typedef enum logic [3:0] {
        TPWMC_SEL_NONE = 4'h0,
        TPWMC_SEL_SC   = 4'h1,
        TPWMC_SEL_CNTH = 4'h2,
        TPWMC_SEL_CNTL = 4'h3,
        TPWMC_SEL_MODH = 4'h4,
        TPWMC_SEL_MODL = 4'h5,
        TPWMC_SEL_SOPT = 4'h6,
        TPWMC_SEL_CH0  = 4'h7,
        TPWMC_SEL_CH1  = 4'h8
    } tpwmc_sel_t;
endpackage
`default_nettype wire

// File: rtl/tpwmc_core.sv
// Timer/PWM counter core with APB register slave
// Functional notes
// - Clock source field picks off, bus, crystal
// - Prescaler divides by two to field power
// - Prescaler follows source sync and selector
// - Crystal clock synchronised before prescaler
// - Crystal clock used only when selected
// - Sixteen-bit free, modulo or up/down counter
// - Modulo zero or all-ones runs free
// - Counter reads never disturb counting
// - Any counter byte write clears counter
// - Up mode: flag on roll to zero
// - Center mode: flag on turn downward
// - Clear flag by read then write zero
// - Overflow mid-sequence restarts clear sequence
// - Writing one ignored; reset clears flag
// - Enable and flag request interrupt, except while only half the modulo is written
// - Center select forces up/down and PWM
// - Channels select capture, compare or PWM
// - Option bit routes channel 0 input
// - Owned pins ignore port data, direction
// - Reset: timer off, pins plain inputs
// - Counter byte read latches both bytes
// - Half modulo write suppresses overflow
`default_nettype none
module tpwmc_core
    import tpwmc_pkg::*;
(
    input  wire logic                              mclk,
    input  wire logic                              sys_rst,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [tpwmc_pkg::TPWMC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              crystal_derived_clock,
    input  wire logic                              low_freq_oscillator,
    input  wire logic [1:0]                        pin_in,
    input  wire logic [1:0]                        gpio_data,
    input  wire logic [1:0]                        gpio_dir,
    input  wire logic [1:0]                        gpio_pullup,
    input  wire logic [1:0]                        chan_drive,
    output logic      [1:0]                        pin_out,
    output logic      [1:0]                        pin_oe_n,
    output logic      [1:0]                        pin_pullup,
    output logic      [1:0]                        chan_input,
    output logic      [3:0]                        channel_mode_select,
    output logic                                   center_aligned_pwm,
    output logic      [15:0]                       counter_value,
    output logic                                   count_tick,
    output logic                                   overflow_irq
);
    import tpwmc_pkg::*;

    typedef struct packed {
        logic        irq_en;
        logic        center;
        logic [1:0]  clk_src;
        logic [2:0]  prescale;
        logic        ovf_flag;
        logic        ovf_armed;
        logic [15:0] cnt;
        logic        cnt_down;
        logic [15:0] mod_val;
        logic        mod_pending;
        logic        mod_pend_hi;
        logic        lat_valid;
        logic        lat_hi_first;
        logic [15:0] lat_buf;
        logic [TPWMC_PRE_W-1:0] pre_cnt;
        logic        dx_s1;
        logic        dx_s2;
        logic        dx_s3;
        logic        route_sel;
        logic [3:0]  ch_mode;
        logic [31:0] rdata;
    } tpwmc_state_t;

    tpwmc_state_t st;
    tpwmc_state_t next_st;

    function automatic tpwmc_sel_t reg_decode(input logic [TPWMC_ADDR_W-1:0] a);
        tpwmc_sel_t s;
        s = TPWMC_SEL_NONE;
        if (a[1:0] == 2'h0 && a[TPWMC_ADDR_W-1:10] == 2'h0) begin
            case (a[9:2])
                TPWMC_IDX_STATUS_CONTROL: s = TPWMC_SEL_SC;
                TPWMC_IDX_COUNTER_HIGH:   s = TPWMC_SEL_CNTH;
                TPWMC_IDX_COUNTER_LOW:    s = TPWMC_SEL_CNTL;
                TPWMC_IDX_MODULO_HIGH:    s = TPWMC_SEL_MODH;
                TPWMC_IDX_MODULO_LOW:     s = TPWMC_SEL_MODL;
                TPWMC_IDX_SYSTEM_OPTION:  s = TPWMC_SEL_SOPT;
                TPWMC_IDX_CHAN0_MODE:     s = TPWMC_SEL_CH0;
                TPWMC_IDX_CHAN1_MODE:     s = TPWMC_SEL_CH1;
                default:                  s = TPWMC_SEL_NONE;
            endcase
        end
        return s;
    endfunction

    function automatic logic [TPWMC_PRE_W-1:0] prescale_mask(input logic [2:0] ps);
        logic [7:0] one_hot;
        one_hot = 8'h01 << ps;
        return TPWMC_PRE_W'(one_hot - 8'h01);
    endfunction

    tpwmc_sel_t sel;
    logic       setup_rd;
    logic       access_wr;
    logic       sc_wr;
    logic       cnt_wr;
    logic       src_tick;
    logic       pre_tick;
    logic       ovf_ev;
    logic       mod_free;
    logic [15:0] top;
    logic [1:0] pin_owned;
    logic [1:0] pin_driven;

    assign sel       = reg_decode(paddr);
    assign setup_rd  = psel && !penable && !pwrite;
    assign access_wr = psel && penable && pwrite;
    assign sc_wr     = access_wr && sel == TPWMC_SEL_SC;
    assign cnt_wr    = access_wr && (sel == TPWMC_SEL_CNTH || sel == TPWMC_SEL_CNTL);
    assign mod_free  = st.mod_val == TPWMC_CNT_ZERO || st.mod_val == TPWMC_CNT_MAX;
    assign top       = mod_free ? TPWMC_CNT_MAX : st.mod_val;

    // Source select after sync; code 10 behaves as no source
    always_comb begin
        case (st.clk_src)
            TPWMC_CLK_BUS:  src_tick = 1'b1;
            TPWMC_CLK_XTAL: src_tick = st.dx_s2 && !st.dx_s3;
            default:        src_tick = 1'b0;
        endcase
    end

    // Tick when every selected low bit of the prescaler is set
    assign pre_tick = src_tick &&
        ((st.pre_cnt & prescale_mask(st.prescale)) == prescale_mask(st.prescale));

    // Overflow event, held off while only half of the modulo is written
    always_comb begin
        ovf_ev = 1'b0;
        if (pre_tick && !cnt_wr && !st.mod_pending) begin
            if (st.center) begin
                ovf_ev = !st.cnt_down && st.cnt >= top;
            end else begin
                ovf_ev = st.cnt == top || st.cnt == TPWMC_CNT_MAX;
            end
        end
    end

    always_comb begin
        next_st = st;
        next_st.rdata = st.rdata;
        // Crystal clock synchroniser; first stage feeds only the second
        next_st.dx_s1 = crystal_derived_clock;
        next_st.dx_s2 = st.dx_s1;
        next_st.dx_s3 = st.dx_s2;
        if (src_tick) begin
            next_st.pre_cnt = st.pre_cnt + TPWMC_PRE_W'(1);
        end
        // Counter advance
        if (pre_tick) begin
            if (st.center) begin
                if (!st.cnt_down) begin
                    if (st.cnt >= top) begin
                        next_st.cnt      = top - 16'h0001;
                        next_st.cnt_down = 1'b1;
                    end else begin
                        next_st.cnt = st.cnt + 16'h0001;
                    end
                end else if (st.cnt == TPWMC_CNT_ZERO) begin
                    next_st.cnt      = 16'h0001;
                    next_st.cnt_down = 1'b0;
                end else begin
                    next_st.cnt = st.cnt - 16'h0001;
                end
            end else begin
                next_st.cnt_down = 1'b0;
                next_st.cnt      = (st.cnt == top) ? TPWMC_CNT_ZERO : st.cnt + 16'h0001;
            end
        end
        // Read side effects are taken in the setup cycle so the data matches
        if (setup_rd) begin
            case (sel)
                TPWMC_SEL_SC: begin
                    next_st.rdata = {24'h0, st.ovf_flag, st.irq_en, st.center,
                                     st.clk_src, st.prescale};
                    if (st.ovf_flag) begin
                        next_st.ovf_armed = 1'b1;
                    end
                end
                TPWMC_SEL_CNTH, TPWMC_SEL_CNTL: begin
                    // Reads only touch the latch, never the counter
                    if (st.lat_valid) begin
                        next_st.rdata = {24'h0, (sel == TPWMC_SEL_CNTH) ?
                                         st.lat_buf[15:8] : st.lat_buf[7:0]};
                        if ((sel == TPWMC_SEL_CNTH) != st.lat_hi_first) begin
                            next_st.lat_valid = 1'b0;
                        end
                    end else begin
                        next_st.rdata = {24'h0, (sel == TPWMC_SEL_CNTH) ?
                                         st.cnt[15:8] : st.cnt[7:0]};
                        next_st.lat_buf      = st.cnt;
                        next_st.lat_valid    = 1'b1;
                        next_st.lat_hi_first = sel == TPWMC_SEL_CNTH;
                    end
                end
                TPWMC_SEL_MODH: next_st.rdata = {24'h0, st.mod_val[15:8]};
                TPWMC_SEL_MODL: next_st.rdata = {24'h0, st.mod_val[7:0]};
                TPWMC_SEL_SOPT: next_st.rdata = {31'h0, st.route_sel};
                TPWMC_SEL_CH0:  next_st.rdata = {30'h0, st.ch_mode[1:0]};
                TPWMC_SEL_CH1:  next_st.rdata = {30'h0, st.ch_mode[3:2]};
                default:        next_st.rdata = 32'h0000_0000;
            endcase
        end
        // Writes take effect at the access edge
        if (access_wr) begin
            case (sel)
                TPWMC_SEL_SC: begin
                    next_st.irq_en    = pwdata[TPWMC_BIT_OVF_IRQ_EN];
                    next_st.center    = pwdata[TPWMC_BIT_CENTER];
                    next_st.clk_src   = pwdata[TPWMC_CLK_SRC_HI:TPWMC_CLK_SRC_LO];
                    next_st.prescale  = pwdata[TPWMC_PRESCALE_HI:0];
                    next_st.lat_valid = 1'b0;
                    next_st.ovf_armed = 1'b0;
                    // Writing one leaves the flag alone
                    if (st.ovf_armed && !pwdata[TPWMC_BIT_OVF_FLAG]) begin
                        next_st.ovf_flag = 1'b0;
                    end
                end
                TPWMC_SEL_CNTH, TPWMC_SEL_CNTL: begin
                    next_st.cnt       = TPWMC_CNT_RESET;
                    next_st.cnt_down  = 1'b0;
                    next_st.lat_valid = 1'b0;
                end
                TPWMC_SEL_MODH, TPWMC_SEL_MODL: begin
                    if (sel == TPWMC_SEL_MODH) begin
                        next_st.mod_val[15:8] = pwdata[7:0];
                    end else begin
                        next_st.mod_val[7:0] = pwdata[7:0];
                    end
                    // Second byte of the pair releases the overflow
                    if (st.mod_pending && st.mod_pend_hi != (sel == TPWMC_SEL_MODH)) begin
                        next_st.mod_pending = 1'b0;
                    end else begin
                        next_st.mod_pending = 1'b1;
                        next_st.mod_pend_hi = sel == TPWMC_SEL_MODH;
                    end
                end
                TPWMC_SEL_SOPT: next_st.route_sel    = pwdata[TPWMC_BIT_ROUTE_SEL];
                TPWMC_SEL_CH0:  next_st.ch_mode[1:0] = pwdata[1:0];
                TPWMC_SEL_CH1:  next_st.ch_mode[3:2] = pwdata[1:0];
                default: ;
            endcase
        end
        // A fresh overflow wins over a clear and restarts the sequence
        if (ovf_ev) begin
            next_st.ovf_flag  = 1'b1;
            next_st.ovf_armed = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st              <= '0;
            st.clk_src      <= TPWMC_SC_RESET[TPWMC_CLK_SRC_HI:TPWMC_CLK_SRC_LO];
            st.cnt          <= TPWMC_CNT_RESET;
            st.mod_val      <= TPWMC_MOD_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Pin ownership; channel logic sees timer enable through the source field
    for (genvar i = 0; i < TPWMC_CHANNELS; i++) begin : g_pin
        assign pin_owned[i]  = st.clk_src != TPWMC_CLK_NONE &&
                               (st.center || st.ch_mode[2*i +: 2] != TPWMC_MODE_GPIO);
        assign pin_driven[i] = pin_owned[i] &&
                               (st.center || st.ch_mode[2*i +: 2] != TPWMC_MODE_CAPTURE);
        // Port data and direction have no say over an owned pin
        assign pin_out[i]    = pin_driven[i] ? chan_drive[i] : gpio_data[i];
        assign pin_oe_n[i]   = pin_driven[i] ? 1'b0 :
                               (pin_owned[i] ? 1'b1 : !gpio_dir[i]);
        // Pull-up only on a pin that is not being driven
        assign pin_pullup[i] = gpio_pullup[i] && !pin_driven[i];
    end

    assign chan_input[0] = st.route_sel ? low_freq_oscillator : pin_in[0];
    assign chan_input[1] = pin_in[1];
    assign channel_mode_select = st.ch_mode;
    assign center_aligned_pwm  = st.center;
    assign counter_value       = st.cnt;
    assign count_tick          = pre_tick;
    assign overflow_irq        = st.ovf_flag && st.irq_en && !st.mod_pending;

    // Zero-wait slave: data was fetched in the setup cycle
    assign prdata  = st.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && sel == TPWMC_SEL_NONE;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_CLK_OFF_HOLD: assert property (
        (st.clk_src == TPWMC_CLK_NONE || st.clk_src == TPWMC_CLK_UNUSED) && !cnt_wr
        |=> $stable(st.cnt))
        else $error("counter moved with no clock source");
    AST_BUS_EVERY_CYCLE: assert property (
        st.clk_src == TPWMC_CLK_BUS && st.prescale == 3'h0 && !st.center && !cnt_wr
        |=> st.cnt == $past(st.cnt) + 16'h0001 || st.cnt == TPWMC_CNT_ZERO)
        else $error("divide-by-one bus clock did not count every cycle");
    AST_DIV128_SPACING: assert property (
        st.clk_src == TPWMC_CLK_BUS && st.prescale == 3'h7 && pre_tick
        |=> !pre_tick [*8])
        else $error("divide-by-128 ticks too close together");
    AST_XTAL_SYNC_EDGE: assert property (
        st.clk_src == TPWMC_CLK_XTAL && src_tick
        |-> $past(crystal_derived_clock, 2) && !$past(crystal_derived_clock, 3))
        else $error("crystal tick not from synchronised rising edge");
    AST_CNT_WRITE_CLEARS: assert property (
        cnt_wr |=> st.cnt == TPWMC_CNT_ZERO)
        else $error("counter write did not clear counter");
    AST_OVF_UP_ROLL: assert property (
        !st.center && pre_tick && !st.mod_pending && !cnt_wr && st.cnt == top
        |=> st.ovf_flag && st.cnt == TPWMC_CNT_ZERO)
        else $error("up-count roll did not set overflow");
    AST_OVF_CENTER_TURN: assert property (
        $rose(st.cnt_down) && !$past(cnt_wr) |-> st.ovf_flag || $past(st.mod_pending))
        else $error("center turn did not set overflow");
    AST_CLEAR_NEEDS_ARM: assert property (
        $fell(st.ovf_flag) |-> $past(st.ovf_armed) && $past(sc_wr))
        else $error("overflow cleared without arming read");
    AST_NO_SELF_SET: assert property (
        !st.ovf_flag && !ovf_ev |=> !st.ovf_flag)
        else $error("overflow set without an event");
    AST_IRQ_GATE: assert property (
        overflow_irq |-> st.ovf_flag && st.irq_en)
        else $error("interrupt without flag and enable");
    AST_LATCH_HOLDS: assert property (
        st.lat_valid && !access_wr ##1 st.lat_valid |-> $stable(st.lat_buf))
        else $error("counter latch changed while held");
    AST_MOD_PENDING_QUIET: assert property (
        st.mod_pending && !st.ovf_flag |=> !st.ovf_flag)
        else $error("overflow set during half modulo write");
    // Clear sequence, pin ownership and down counting
    AST_READ_ARMS: assert property (
        setup_rd && sel == TPWMC_SEL_SC && st.ovf_flag && !ovf_ev |=> st.ovf_armed)
        else $error("status read with flag set did not arm clear");
    AST_SET_WINS: assert property (
        ovf_ev |=> st.ovf_flag && !st.ovf_armed)
        else $error("overflow did not restart clear sequence");
    AST_ONE_NO_CLEAR: assert property (
        sc_wr && pwdata[TPWMC_BIT_OVF_FLAG] && st.ovf_flag |=> st.ovf_flag)
        else $error("writing one cleared the overflow flag");
    AST_CAPTURE_PIN_INPUT: assert property (
        st.clk_src != TPWMC_CLK_NONE && !st.center && st.ch_mode[3:2] == TPWMC_MODE_CAPTURE
        |-> pin_oe_n[1])
        else $error("capture pin driven by port direction");
    AST_CENTER_DOWN: assert property (
        st.center && st.cnt_down && pre_tick && !cnt_wr && st.cnt != TPWMC_CNT_ZERO
        |=> st.cnt == $past(st.cnt) - 16'h0001)
        else $error("center mode did not count down");

    COV_UP_OVERFLOW:  cover property (!st.center && ovf_ev);
    COV_CENTER_TURN:  cover property (st.center && ovf_ev);
    COV_FLAG_CLEARED: cover property ($fell(st.ovf_flag));
    COV_RACE_KEEP:    cover property (sc_wr && st.ovf_armed && ovf_ev);
    COV_LATCH_READ:   cover property (setup_rd && st.lat_valid);
endmodule
`default_nettype wire

// File: sim/tpwmc_tb.sv
// Self-checking bench for the timer/PWM counter core
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tpwmc_pkg::*;
    localparam logic [7:0] SC = TPWMC_IDX_STATUS_CONTROL, CH = TPWMC_IDX_COUNTER_HIGH,
        CL = TPWMC_IDX_COUNTER_LOW, MH = TPWMC_IDX_MODULO_HIGH, ML = TPWMC_IDX_MODULO_LOW,
        SO = TPWMC_IDX_SYSTEM_OPTION, M0 = TPWMC_IDX_CHAN0_MODE, M1 = TPWMC_IDX_CHAN1_MODE;
    logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, errv;
    logic        crystal_derived_clock, low_freq_oscillator, center_aligned_pwm;
    logic        count_tick, overflow_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [1:0]  pin_in, gpio_data, gpio_dir, gpio_pullup, chan_drive;
    logic [1:0]  pin_out, pin_oe_n, pin_pullup, chan_input;
    logic [3:0]  channel_mode_select;
    logic [15:0] counter_value, lat, a, b;
    int          fail_count, n_tests, c;
    time         t0;

    tpwmc_core dut_u (
        .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .crystal_derived_clock, .low_freq_oscillator, .pin_in, .gpio_data,
        .gpio_dir, .gpio_pullup, .chan_drive, .pin_out, .pin_oe_n, .pin_pullup,
        .chan_input, .channel_mode_select, .center_aligned_pwm, .counter_value,
        .count_tick, .overflow_irq
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Crystal-derived input at 500 kHz, 200 bus cycles per half period
    initial begin
        crystal_derived_clock = 1'b0;
        forever begin
            repeat (200) @(posedge mclk);
            crystal_derived_clock <= ~crystal_derived_clock;
        end
    end

    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen; read side effects land at setup edge, writes at access edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
        int n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= {24'h000000, d};
        @(posedge mclk);
        lat      = counter_value;
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) fail_count++;
        rdv      = prdata;
        errv     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {2'h0, i, 2'h0}, d);
    endtask

    task automatic rd(input logic [7:0] i);
        apb(1'b0, {2'h0, i, 2'h0}, 8'h00);
    endtask

    // Window is a whole number of tick periods, so the count is exact
    task automatic ticks(input int cyc, input int exp);
        int k = 0;
        repeat (cyc) begin
            @(posedge mclk);
            if (count_tick === 1'b1) k++;
        end
        chk(k, exp);
    endtask

    initial begin
        #200000;
        fail_count++;
        end_sim;
    end

    initial begin
        {sys_rst, psel, penable, pwrite, low_freq_oscillator} = 5'h11;
        paddr = 12'h000;
        pwdata = 32'h0;
        // Port direction starts as inputs, as the port comes out of reset
        {pin_in, gpio_data, gpio_dir, gpio_pullup, chan_drive} = 10'h28D;
        fail_count = 0;
        n_tests = 0;
        repeat (12) @(posedge mclk);
        chk(pin_oe_n, 32'h3);
        chk(overflow_irq, 32'h0);
        sys_rst <= 1'b0;
        gpio_dir <= 2'h3;
        rd(SC);
        chk(rdv, 32'h0);
        for (int p = 0; p < 8; p++) begin
            wr(SC, 8'(8'h08 + p));
            ticks(16 << p, 16);
        end
        wr(SC, 8'h18);
        ticks(1600, 4);
        wr(SC, 8'h19);
        ticks(1600, 2);
        wr(SC, 8'h00);
        ticks(300, 0);
        wr(SC, 8'h10);
        ticks(300, 0);
        // Coherent counter read while running from the bus clock
        wr(SC, 8'h08);
        @(posedge mclk);
        a = counter_value;
        t0 = $time;
        rd(CH);
        b = lat;
        chk(rdv, b[15:8]);
        repeat (300) @(posedge mclk);
        rd(CL);
        chk(rdv, b[7:0]);
        @(posedge mclk);
        chk(16'(counter_value - a), 16'(($time - t0) / 5));
        wr(CH, 8'hA5);
        @(posedge mclk);
        chk(counter_value < 16'h0002, 32'h1);
        // Modulo 0x000F with overflow flag handling
        wr(MH, 8'h00);
        wr(ML, 8'h0F);
        wr(CL, 8'h00);
        a = 16'h0000;
        repeat (40) begin
            @(posedge mclk);
            if (counter_value > a) a = counter_value;
        end
        chk(a, 16'h000F);
        rd(SC);
        chk(rdv, 32'h88);
        wr(SC, 8'hC0);
        @(posedge mclk);
        chk(overflow_irq, 32'h1);
        wr(MH, 8'h00);
        @(posedge mclk);
        chk(overflow_irq, 32'h0);
        wr(ML, 8'h0F);
        @(posedge mclk);
        chk(overflow_irq, 32'h1);
        rd(SC);
        chk(rdv, 32'hC0);
        wr(SC, 8'h40);
        rd(SC);
        chk(rdv, 32'h40);
        chk(overflow_irq, 32'h0);
        wr(SC, 8'hC0);
        rd(SC);
        chk(rdv, 32'h40);
        // New overflow between arming read and clearing write
        wr(SC, 8'h48);
        repeat (40) @(posedge mclk);
        rd(SC);
        chk(rdv, 32'hC8);
        repeat (20) @(posedge mclk);
        wr(SC, 8'h40);
        rd(SC);
        chk(rdv, 32'hC0);
        wr(SC, 8'h20);
        // Up/down counting with modulo 4
        wr(MH, 8'h00);
        wr(ML, 8'h04);
        wr(CL, 8'h00);
        wr(SC, 8'h28);
        c = 0;
        while (counter_value !== 16'h0004 && c < 20) begin
            @(posedge mclk);
            c++;
        end
        @(posedge mclk);
        chk(counter_value, 16'h0003);
        chk(center_aligned_pwm, 32'h1);
        rd(SC);
        chk(rdv[7], 32'h1);
        // Pin ownership: channel 0 output, channel 1 capture
        wr(M0, 8'h02);
        wr(M1, 8'h01);
        wr(SC, 8'h08);
        @(posedge mclk);
        chk(channel_mode_select, 32'h6);
        chk(pin_oe_n, 32'h2);
        chk(pin_out, 32'h3);
        chk(pin_pullup, 32'h2);
        chk(chan_input, 32'h2);
        wr(SO, 8'h01);
        @(posedge mclk);
        chk(chan_input, 32'h3);
        wr(SC, 8'h00);
        @(posedge mclk);
        chk(pin_oe_n, 32'h0);
        apb(1'b0, 12'hFFC, 8'h00);
        chk(errv, 32'h1);
        chk(rdv, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
